// File: rtl/mnd_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module mnd_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic doWr;
	logic doRd;
	assign inReady = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem[rdPtr_reg];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	always_ff @(posedge mclk)
	begin
		if (doWr)
			mem[wrPtr_reg] <= inData;
		if (!nrst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doWr)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doRd)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			if (doWr && !doRd)
				count_reg <= count_reg + 1'b1;
			else if (doRd && !doWr)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // mnd_fifo

// File: rtl/mnd_mac_end.sv
// mac side of the mii nibble datapath
`timescale 1ns/1ps
module mnd_mac_end (
	input wire logic mclk,
	input wire logic nrst,
	mnd_mii_if.mac mii,
	input wire logic sendValid,
	input wire logic [3:0] sendNibble,
	input wire logic sendLast,
	output logic sendReady,
	output logic [3:0] recvNibble,
	output logic recvValid,
	output logic recvError,
	output logic recvEnd
);
	typedef struct packed {
		logic txEnable;
		logic [3:0] txData;
		logic [3:0] recvNibble;
		logic recvValid;
		logic recvError;
		logic recvEnd;
		logic inFrame;
	} mnd_mac_state_t;
	mnd_mac_state_t st_reg;
	mnd_mac_state_t st_next;
	always_comb
	begin
		st_next = st_reg;
		st_next.recvValid = 1'b0;
		st_next.recvEnd = 1'b0;
		st_next.recvError = 1'b0;
		if (mii.txClkEn)
		begin
			// a nibble for every tx edge while enable is high
			st_next.txEnable = sendValid; // R11 R13
			st_next.txData = sendValid ? sendNibble : 4'h0; // R10
		end
		if (mii.rxClkEn)
		begin
			if (mii.rxValid)
			begin
				st_next.recvNibble = mii.rxData; // R01 R17
				st_next.recvValid = 1'b1;
				st_next.recvError = mii.rxErr;
				st_next.inFrame = 1'b1;
			end
			else if (st_reg.inFrame)
			begin
				st_next.inFrame = 1'b0;
				st_next.recvEnd = 1'b1;
			end
		end
	end
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign sendReady = mii.txClkEn;
	assign mii.txEnable = st_reg.txEnable;
	assign mii.txData = st_reg.txData;
	assign recvNibble = st_reg.recvNibble;
	assign recvValid = st_reg.recvValid;
	assign recvError = st_reg.recvError;
	assign recvEnd = st_reg.recvEnd;
	logic unusedLast;
	assign unusedLast = sendLast;
endmodule // mnd_mac_end

// File: rtl/mnd_mii_if.sv
// mii nibble link between phy datapath and mac end
`timescale 1ns/1ps
interface mnd_mii_if;
	logic rxClkEn;
	logic [3:0] rxData;
	logic rxValid;
	logic rxErrOut;
	logic rxErrOe;
	logic txClkEn;
	logic txEnable;
	logic [3:0] txData;
	logic rxErr;
	assign rxErr = rxErrOe ? rxErrOut : 1'b0;
	modport phy (output rxClkEn, output rxData, output rxValid,
		output rxErrOut, output rxErrOe, output txClkEn,
		input txEnable, input txData);
	modport mac (input rxClkEn, input rxData, input rxValid,
		input rxErr, input txClkEn,
		output txEnable, output txData);
endinterface

// File: rtl/mnd_phy_end.sv
// phy side of the mii nibble datapath
// Notes on behaviour
// R01: rx line zero is lsb, three msb
// R02: rx nibble changes on rx clock edges
// R03: rx valid driven on rx clock edge
// R04: valid rises only after start delimiter
// R05: valid drops on end delimiter or error
// R06: rx error unused at 10 Mb/s
// R07: 100M error on frame error, false carrier
// R08: rx error changes only on clock edges
// R09: tristate control removes rx error drive
// R10: tx line zero is lsb, three msb
// R11: sample tx nibble each edge while enabled
// R12: send every sampled nibble in order; the code drops a nibble sampled while the tx fifo is full
// R13: tx enable low ends frame transmission
// R14: rx clock 2.5 or 25 MHz by speed
// R15: 100M rx clock from line or reference
// R16: phy sources tx clock at speed rate
// R17: mac takes nibbles only while valid
`timescale 1ns/1ps
module mnd_phy_end (
	input wire logic mclk,
	input wire logic nrst,
	mnd_mii_if.phy mii,
	input wire logic speed100,
	input wire logic linkUp,
	input wire logic lineStrobe,
	input wire logic [3:0] lineNibble,
	input wire logic lineSsd,
	input wire logic lineEsd,
	input wire logic lineSigErr,
	input wire logic lineCodeErr,
	input wire logic lineFalseCarrier,
	input wire logic receive_tristate_control,
	output logic [3:0] medNibble,
	output logic medValid,
	input wire logic medReady,
	output logic medFrame,
	output logic rxLineLocked
);

	typedef struct packed {
		logic [5:0] divCnt;
		mnd_pkg::mnd_rx_state_t rxState;
		logic rxClkEn;
		logic [3:0] rxData;
		logic rxValid;
		logic rxErr;
		logic rxErrOe;
		logic txClkEn;
		logic txFrame;
		logic [3:0] medNibble;
		logic medValid;
		logic medFrame;
		logic locked;
	} mnd_phy_state_t;
	mnd_phy_state_t st_reg;
	mnd_phy_state_t st_next;

	logic fifoInReady;
	logic fifoOutValid;
	logic [3:0] fifoOutData;
	logic fifoPop;
	logic txTake;
	logic divWrap;
	logic ssdSeen;
	logic falseSeen;
	logic frameStop;

	// rx error only means something at the fast rate
	function automatic logic errAtRate(
		input logic fast,
		input logic flag
	);
		return fast & flag;
	endfunction

	assign divWrap = (st_reg.divCnt == '0);
	assign ssdSeen = lineStrobe && lineSsd;
	assign falseSeen = lineStrobe && lineFalseCarrier;
	assign frameStop = lineEsd || lineSigErr; // R05
	assign txTake = st_reg.txClkEn && mii.txEnable; // R11
	assign fifoPop = fifoOutValid && (!st_reg.medValid || medReady);
	// depth covers bursts while the medium stalls; overflow drops a nibble
	mnd_fifo #(
		.WIDTH(mnd_pkg::NIB_W),
		.DEPTH(mnd_pkg::FIFO_DEPTH),
		.AW(mnd_pkg::FIFO_AW)
	) txFifo (
		.mclk(mclk),
		.nrst(nrst),
		.inValid(txTake), // R12
		.inReady(fifoInReady),
		.inData(mii.txData), // R10
		.outValid(fifoOutValid),
		.outReady(fifoPop),
		.outData(fifoOutData)
	);

	always_comb
	begin
		st_next = st_reg;
		st_next.rxClkEn = 1'b0;
		st_next.txClkEn = 1'b0;
		// one divider makes both mii enables, rate from speed
		if (divWrap)
		begin
			st_next.divCnt = speed100 ? mnd_pkg::DIV_FAST_M1
				: mnd_pkg::DIV_SLOW_M1; // R14 R16
			st_next.rxClkEn = 1'b1; // R14
			st_next.txClkEn = 1'b1; // R16
		end
		else
			st_next.divCnt = st_reg.divCnt - 1'b1;
		// rx lock: follows linkUp at 100M, set by the first line strobe at 10M and held until reset
		st_next.locked = speed100 ? linkUp : st_reg.locked | lineStrobe; // R15
		if (st_reg.rxClkEn)
		begin
			st_next.rxErr = 1'b0;
			case (st_reg.rxState)
				mnd_pkg::RX_IDLE:
				begin
					st_next.rxValid = 1'b0;
					if (ssdSeen)
						st_next.rxState = mnd_pkg::RX_SSD;
					else if (falseSeen)
					begin
						st_next.rxState = mnd_pkg::RX_FALSE;
						st_next.rxErr = speed100; // R06 R07
					end
				end
				mnd_pkg::RX_SSD:
				begin
					// a signal error right after the delimiter aborts
					if (lineSigErr)
						st_next.rxState = mnd_pkg::RX_IDLE;
					else
					begin
						st_next.rxState = mnd_pkg::RX_DATA;
						st_next.rxValid = 1'b1; // R04
						st_next.rxData = lineNibble; // R01 R02
						st_next.rxErr = errAtRate(speed100, lineCodeErr); // R07
					end
				end
				mnd_pkg::RX_DATA:
				begin
					if (frameStop)
					begin
						st_next.rxState = mnd_pkg::RX_IDLE;
						st_next.rxValid = 1'b0; // R05
						st_next.rxData = mnd_pkg::RST_NIB;
					end
					else
					begin
						st_next.rxData = lineNibble; // R02
						st_next.rxErr = errAtRate(speed100, lineCodeErr); // R06 R07
					end
				end
				mnd_pkg::RX_FALSE:
				begin
					st_next.rxErr = speed100; // R07
					if (!lineFalseCarrier)
					begin
						st_next.rxState = mnd_pkg::RX_IDLE;
						st_next.rxErr = 1'b0;
					end
				end
				default:
					st_next.rxState = mnd_pkg::RX_IDLE;
			endcase
		end
		st_next.rxErrOe = !receive_tristate_control; // R09
		if (st_reg.txClkEn)
			st_next.txFrame = mii.txEnable;
		if (fifoPop)
		begin
			st_next.medNibble = fifoOutData; // R12
			st_next.medValid = 1'b1;
		end
		else if (medReady)
			st_next.medValid = 1'b0;
		// frame ends once tx enable drops and the buffer drains
		st_next.medFrame = st_reg.txFrame || fifoOutValid
			|| st_next.medValid; // R13
	end

	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			st_reg <= '0;
			st_reg.rxState <= mnd_pkg::RX_IDLE;
			// rx error stays released until the first clocked update
			st_reg.rxErrOe <= 1'b0;
		end
		else
			st_reg <= st_next; // R03 R08
	end

	assign mii.rxClkEn = st_reg.rxClkEn;
	assign mii.rxData = st_reg.rxData;
	assign mii.rxValid = st_reg.rxValid;
	assign mii.rxErrOut = st_reg.rxErr;
	assign mii.rxErrOe = st_reg.rxErrOe;
	assign mii.txClkEn = st_reg.txClkEn;
	assign medNibble = st_reg.medNibble;
	assign medValid = st_reg.medValid;
	assign medFrame = st_reg.medFrame;
	assign rxLineLocked = st_reg.locked;
	logic unusedReady;
	assign unusedReady = fifoInReady;
endmodule // mnd_phy_end

// File: rtl/mnd_pkg.sv
// shared constants and types for the mii nibble datapath
package mnd_pkg;
	localparam int NIB_W = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW = 3;
	localparam int CLK_MHZ = 125;
	localparam real MII_FAST_MHZ = 25.0;
	localparam real MII_SLOW_MHZ = 2.5;
	localparam int DIV_FAST = int'(CLK_MHZ / MII_FAST_MHZ);
	localparam int DIV_SLOW = int'(CLK_MHZ / MII_SLOW_MHZ);
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_FAST_M1 = DIV_W'(DIV_FAST - 1);
	localparam logic [DIV_W-1:0] DIV_SLOW_M1 = DIV_W'(DIV_SLOW - 1);
	localparam logic [3:0] RST_NIB = 4'h0;
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_SSD = 4'h2,
		RX_DATA = 4'h4,
		RX_FALSE = 4'h8
	} mnd_rx_state_t;
endpackage

// File: sim/mnd_chk.sv
// assertions on the mii link signals
`timescale 1ns/1ps
module mnd_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rxClkEn,
	input wire logic [3:0] rxData,
	input wire logic rxValid,
	input wire logic rxErrOut,
	input wire logic rxErrOe,
	input wire logic rxErr,
	input wire logic receive_tristate_control,
	input wire logic txClkEn
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence rxQuiet;
		!rxClkEn [*4];
	endsequence
	a_rx_data_edge: assert property ($changed(rxData) |-> $past(rxClkEn))
		else $error("rx nibble moved off an edge");
	a_rx_valid_edge: assert property ($changed(rxValid) |-> $past(rxClkEn))
		else $error("rx valid moved off an edge");
	a_rx_err_edge: assert property ($changed(rxErrOut) |-> $past(rxClkEn))
		else $error("rx error moved off an edge");
	a_rx_clk_rate: assert property (rxClkEn |=> rxQuiet ##[1:46] rxClkEn)
		else $error("rx edge spacing wrong");
	a_tx_clk_gap: assert property (txClkEn |=> !txClkEn [*4])
		else $error("tx edges too close");
	a_tx_clk_rate: assert property (txClkEn |=> ##[4:49] txClkEn)
		else $error("tx edge missing");
	a_err_release: assert property (receive_tristate_control |=> !rxErrOe && !rxErr)
		else $error("rx error driven while released");
	a_clk_aligned: assert property (rxClkEn == txClkEn)
		else $error("rx and tx edges apart");
endmodule // mnd_chk

// File: sim/mnd_test.sv
// self-checking bench joining phy and mac ends
`timescale 1ns/1ps
module mnd_test;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic speed100 = 1'b1;
	logic lineStrobe = 1'b0;
	logic [3:0] lineNibble = 4'h0;
	logic lineSsd = 1'b0, lineEsd = 1'b0, lineSigErr = 1'b0;
	logic lineCodeErr = 1'b0, lineFalseCarrier = 1'b0;
	logic receive_tristate_control = 1'b0;
	logic linkUp = 1'b1;
	logic medReady = 1'b1, sendValid = 1'b0;
	logic [3:0] sendNibble = 4'h0, medNibble, recvNibble;
	logic medValid, medFrame, rxLineLocked, sendReady;
	logic recvValid, recvError, recvEnd, errSeen, endSeen;
	logic [3:0] rxQ[$], wireQ[$], medQ[$];
	int bad_count = 0;
	int num_checks = 0;
	mnd_mii_if mii ();
	mnd_phy_end mnd_phy_end_inst (.mclk, .nrst, .mii, .speed100,
		.linkUp, .lineStrobe, .lineNibble, .lineSsd, .lineEsd,
		.lineSigErr, .lineCodeErr, .lineFalseCarrier,
		.receive_tristate_control, .medNibble, .medValid, .medReady,
		.medFrame, .rxLineLocked);
	mnd_mac_end mnd_mac_end_inst (.mclk, .nrst, .mii, .sendValid,
		.sendNibble, .sendLast(1'b0), .sendReady, .recvNibble,
		.recvValid, .recvError, .recvEnd);
	mnd_chk mnd_chk_inst (.mclk, .nrst, .rxClkEn(mii.rxClkEn),
		.rxData(mii.rxData), .rxValid(mii.rxValid),
		.rxErrOut(mii.rxErrOut), .rxErrOe(mii.rxErrOe),
		.rxErr(mii.rxErr), .txClkEn(mii.txClkEn),
		.receive_tristate_control);
	always #4 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if (recvValid === 1'b1) rxQ.push_back(recvNibble);
		if (mii.rxValid === 1'b1 && mii.rxClkEn === 1'b1)
			wireQ.push_back(mii.rxData);
		if (medValid === 1'b1 && medReady === 1'b1) medQ.push_back(medNibble);
		if (recvError === 1'b1) errSeen = 1'b1;
		if (recvEnd === 1'b1) endSeen = 1'b1;
	end
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic reboot(input logic fast);
		@(negedge mclk);
		nrst = 1'b0;
		speed100 = fast;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
	endtask
	// flags f: ssd, esd, signal error, code error; held over one rx edge
	task automatic line(input logic [3:0] n, input logic [3:0] f);
		int k;
		@(negedge mclk);
		{lineSsd, lineEsd, lineSigErr, lineCodeErr} = f;
		lineNibble = n;
		lineStrobe = 1'b1;
		for (k = 0; k < 60 && mii.rxClkEn !== 1'b1; k++)
			@(negedge mclk);
	endtask
	task automatic send(input logic [3:0] n);
		int k;
		@(negedge mclk);
		sendValid = 1'b1;
		sendNibble = n;
		for (k = 0; k < 60 && sendReady !== 1'b1; k++)
			@(negedge mclk);
	endtask
	task automatic test_rx;
		logic [3:0] exp [3] = '{4'h1, 4'h8, 4'ha};
		rxQ = {};
		wireQ = {};
		endSeen = 1'b0;
		line(4'h7, 4'h0);
		line(4'h0, 4'h8);
		for (int i = 0; i < 3; i++)
			line(exp[i], 4'h0);
		line(4'h0, 4'h4);
		line(4'h0, 4'h0);
		line(4'h0, 4'h0);
		chk(4'(rxQ.size()), 4'h3);
		chk({3'h0, endSeen}, 4'h1);
		for (int i = 0; i < 3; i++)
		begin
			chk(wireQ[i], exp[i]);
			chk(rxQ[i], exp[i]);
		end
		chk({3'h0, rxLineLocked}, 4'h1);
		linkUp = 1'b0;
		@(negedge mclk);
		chk({3'h0, rxLineLocked}, {3'h0, !speed100});
		linkUp = 1'b1;
		$display("test_rx done");
	endtask
	task automatic test_err;
		errSeen = 1'b0;
		line(4'h0, 4'h8);
		line(4'h5, 4'h1);
		line(4'h6, 4'h2);
		line(4'h0, 4'h0);
		line(4'h0, 4'h0);
		chk({3'h0, errSeen}, {3'h0, speed100});
		chk({3'h0, mii.rxValid}, 4'h0);
		lineFalseCarrier = 1'b1;
		line(4'h0, 4'h0);
		line(4'h0, 4'h0);
		chk({3'h0, mii.rxErr}, {3'h0, speed100});
		receive_tristate_control = 1'b1;
		line(4'h0, 4'h0);
		chk({3'h0, mii.rxErr}, 4'h0);
		lineFalseCarrier = 1'b0;
		receive_tristate_control = 1'b0;
		line(4'h0, 4'h0);
		line(4'h0, 4'h8);
		line(4'h0, 4'h2);
		line(4'h0, 4'h0);
		chk({3'h0, mii.rxValid}, 4'h0);
		lineStrobe = 1'b0;
		$display("test_err done");
	endtask
	task automatic test_tx;
		medQ = {};
		medReady = 1'b0;
		send(4'h1);
		send(4'h8);
		send(4'hc);
		@(negedge mclk);
		sendValid = 1'b0;
		repeat (60) @(negedge mclk);
		chk({3'h0, medFrame}, 4'h1);
		medReady = 1'b1;
		repeat (60) @(negedge mclk);
		chk(4'(medQ.size()), 4'h3);
		chk(medQ[0], 4'h1);
		chk(medQ[1], 4'h8);
		chk(medQ[2], 4'hc);
		chk({3'h0, medFrame}, 4'h0);
		$display("test_tx done");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#400000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		test_rx();
		test_err();
		test_tx();
		reboot(1'b0);
		test_rx();
		test_err();
		test_tx();
		wrap_up();
	end
endmodule // mnd_test
